// ### include/pwm_timing_pkg.sv
/*
 * constants for the synced pwm phase and rate setup block.
 * assumes a 250 mhz system clock and a sync line sampled on it.
 */
package pwm_timing_pkg;
	// system clock
	localparam int unsigned CLK_HZ      = 250_000_000;
	// switching rates, in hz
	localparam int unsigned RATE0_HZ    = 500_000;
	localparam int unsigned RATE1_HZ    = 750_000;
	localparam int unsigned RATE2_HZ    = 1_000_000;
	// switching period counts derived from the clock
	localparam logic [8:0]  PER0_CYC    = 9'(CLK_HZ / RATE0_HZ);
	localparam logic [8:0]  PER1_CYC    = 9'(CLK_HZ / RATE1_HZ);
	localparam logic [8:0]  PER2_CYC    = 9'(CLK_HZ / RATE2_HZ);
	// register select codes on the setup port
	localparam logic        SEL_SETUP   = 1'b0;
	localparam logic        SEL_CEIL    = 1'b1;
	// setup register fields
	localparam int unsigned RATE_MSB    = 7;
	localparam int unsigned RATE_LSB    = 5;
	localparam int unsigned LAG_MSB     = 4;
	localparam int unsigned LAG_LSB     = 0;
	localparam logic [2:0]  RATE_500K   = 3'h0;
	localparam logic [2:0]  RATE_750K   = 3'h1;
	localparam logic [2:0]  RATE_1M     = 3'h2;
	// duty ceiling register fields
	localparam int unsigned CEIL_MSB    = 7;
	localparam int unsigned CEIL_LSB    = 2;
	localparam int unsigned SAT_HI_BIT  = 1;
	localparam int unsigned SAT_LO_BIT  = 0;
	// scaling denominators: 32 lag steps, ceiling in 1/192
	localparam int unsigned LAG_DEN     = 32;
	localparam int unsigned CEIL_DEN    = 192;
	// reset values
	localparam logic [7:0]  SETUP_RST   = 8'h00;
	localparam logic [7:0]  CEIL_RST    = 8'he8;
endpackage : pwm_timing_pkg

// ### logic/frac_scale.sv
/*
 * scales a period count by code/den, rounding down.
 * assumes den is a constant so the divide folds to logic.
 */
`timescale 1ns/10ps
module frac_scale #(
	parameter int unsigned DEN = 32
) (
	input  wire logic [8:0] period,
	input  wire logic [5:0] code,
	output logic      [8:0] scaled
);
	logic [14:0] prod;

	// product fits 15 bits, quotient never exceeds the period
	always_comb begin
		prod   = 15'(period * code);
		scaled = 9'(prod / 15'(DEN));
	end
endmodule : frac_scale

// ### logic/synced_pwm_phase_and_rate_setup.sv
/*
 * pwm timing: rate select, phase lag to sync line, duty ceiling.
 * assumes the sync line and setup port are synchronous to CLK.
 */
// Operation
// - setup changes only while converter off
// - switching synchronised to master sync clock
// - switching clock derived from master via divider; the divider here counts CLK cycles and is only realigned on master edges
// - rate code selects 500k, 750k, 1m
// - rate setting independent of other units
// - lag measured from sync edge to on-time
// - lag is code times 11.25 degrees
// - lag applied as set, unit count ignored
// - duty capped at programmed ceiling
// - ceiling is six-bit code over 192
// - saturation forces ceiling or zero per cycle
`timescale 1ns/10ps
module synced_pwm_phase_and_rate_setup (
	input  wire logic       CLK,
	input  wire logic       RESET_N,
	input  wire logic       SYNC_IN,
	input  wire logic       CONV_ON,
	input  wire logic       REG_WR,
	input  wire logic       REG_SEL,
	input  wire logic [7:0] REG_WDATA,
	output logic      [7:0] REG_RDATA,
	input  wire logic [8:0] DUTY_REQ,
	input  wire logic       ERR_HIGH,
	input  wire logic       ERR_LOW,
	output logic            PWM_OUT
);
	logic       rst_a_q;
	logic       rst_n_q;
	logic [7:0] setup_q;
	logic [7:0] ceil_reg_q;
	logic       sync_q;
	logic       sync_edge;
	logic [8:0] period_cyc;
	logic [8:0] lag_cyc;
	logic [8:0] ceil_cyc;
	logic [8:0] cnt_q;
	logic [8:0] pos;
	logic [8:0] on_q;
	logic [8:0] on_d;
	logic [8:0] on_now;
	logic       pwm_q;
	logic       locked_q;
	logic [2:0] rate_code;
	logic       upper_saturation_enable;
	logic       negative_saturation_enable;

	assign rate_code = setup_q[pwm_timing_pkg::RATE_MSB:
		pwm_timing_pkg::RATE_LSB];
	assign upper_saturation_enable =
		ceil_reg_q[pwm_timing_pkg::SAT_HI_BIT];
	assign negative_saturation_enable =
		ceil_reg_q[pwm_timing_pkg::SAT_LO_BIT];

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_a_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_a_q <= 1'b1;
			rst_n_q <= rst_a_q;
		end
	end

	// setup register: frozen while running so a live unit never retimes
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			setup_q <= pwm_timing_pkg::SETUP_RST;
		end else if (REG_WR && REG_SEL == pwm_timing_pkg::SEL_SETUP &&
			!CONV_ON) begin
			setup_q <= REG_WDATA;
		end
	end

	// duty ceiling and saturation enables, writable any time
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			ceil_reg_q <= pwm_timing_pkg::CEIL_RST;
		end else if (REG_WR && REG_SEL == pwm_timing_pkg::SEL_CEIL) begin
			ceil_reg_q <= REG_WDATA;
		end
	end

	// read back of the selected register
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			REG_RDATA <= 8'h00;
		end else if (REG_SEL == pwm_timing_pkg::SEL_CEIL) begin
			REG_RDATA <= ceil_reg_q;
		end else begin
			REG_RDATA <= setup_q;
		end
	end

	// rate code to period; unused codes fall back to the lowest rate
	always_comb begin
		if (rate_code == pwm_timing_pkg::RATE_750K) begin
			period_cyc = pwm_timing_pkg::PER1_CYC;
		end else if (rate_code == pwm_timing_pkg::RATE_1M) begin
			period_cyc = pwm_timing_pkg::PER2_CYC;
		end else begin
			period_cyc = pwm_timing_pkg::PER0_CYC;
		end
	end

	// lag is code/32 of the period, one step being 11.25 degrees
	frac_scale #(
		.DEN    (pwm_timing_pkg::LAG_DEN)
	) u_lag (
		.period (period_cyc),
		.code   ({1'b0, setup_q[pwm_timing_pkg::LAG_MSB:
			pwm_timing_pkg::LAG_LSB]}),
		.scaled (lag_cyc)
	);

	// ceiling is code/192 of the period
	frac_scale #(
		.DEN    (pwm_timing_pkg::CEIL_DEN)
	) u_ceil (
		.period (period_cyc),
		.code   (ceil_reg_q[pwm_timing_pkg::CEIL_MSB:
			pwm_timing_pkg::CEIL_LSB]),
		.scaled (ceil_cyc)
	);

	// sync edge detect; the line is already synchronous to CLK
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			sync_q <= 1'b0;
		end else begin
			sync_q <= SYNC_IN;
		end
	end
	assign sync_edge = SYNC_IN && !sync_q;

	// period divider, realigned on every master edge so it stays locked;
	// each unit uses only its own rate, so mixed rates share one line
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			cnt_q <= 9'h000;
		end else if (sync_edge) begin
			cnt_q <= 9'h000;
		end else if (cnt_q >= period_cyc - 9'h001) begin
			cnt_q <= 9'h000;
		end else begin
			cnt_q <= cnt_q + 9'h001;
		end
	end

	// lock flag: no switching before the first master edge
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			locked_q <= 1'b0;
		end else if (sync_edge) begin
			locked_q <= 1'b1;
		end
	end

	// position within the cycle counted from the lagged on-time start
	always_comb begin
		if (cnt_q >= lag_cyc) begin
			pos = cnt_q - lag_cyc;
		end else begin
			pos = 9'(cnt_q + period_cyc - lag_cyc);
		end
	end

	// on-time chosen once per cycle; saturation wins over the loop
	always_comb begin
		if (upper_saturation_enable && ERR_HIGH) begin
			on_d = ceil_cyc;
		end else if (negative_saturation_enable && ERR_LOW) begin
			on_d = 9'h000;
		end else if (DUTY_REQ > ceil_cyc) begin
			on_d = ceil_cyc;
		end else begin
			on_d = DUTY_REQ;
		end
	end

	// latch on-time at cycle start so a pulse is never cut mid-way
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			on_q <= 9'h000;
		end else if (pos == 9'h000) begin
			on_q <= on_d;
		end
	end

	// the cycle starting now uses its fresh on-time at once, so a pulse
	// never starts late or runs one cycle short after an on-time change
	always_comb begin
		if (pos == 9'h000) begin
			on_now = on_d;
		end else begin
			on_now = on_q;
		end
	end

	// pwm output, held low while off or unlocked
	always_ff @(posedge CLK or negedge rst_n_q) begin
		if (!rst_n_q) begin
			pwm_q <= 1'b0;
		end else begin
			pwm_q <= CONV_ON && locked_q && (pos < on_now);
		end
	end
	assign PWM_OUT = pwm_q;

	a_setup_frozen: assert property (@(posedge CLK) disable iff (!rst_n_q)
		CONV_ON |=> $stable(setup_q))
		else $error("setup changed while running");

	a_rate_reset: assert property (@(posedge CLK)
		$rose(rst_n_q) |-> rate_code == 3'h0)
		else $error("rate not cleared at reset");

	a_period_map: assert property (@(posedge CLK) disable iff (!rst_n_q)
		rate_code == pwm_timing_pkg::RATE_1M |->
		period_cyc == pwm_timing_pkg::PER2_CYC)
		else $error("1m rate period wrong");

	a_sync_align: assert property (@(posedge CLK) disable iff (!rst_n_q)
		sync_edge |=> cnt_q == 9'h000 && locked_q)
		else $error("divider not realigned on sync");

	a_divider_wrap: assert property (@(posedge CLK) disable iff (!rst_n_q)
		!sync_edge && cnt_q == period_cyc - 9'h001 && $stable(setup_q)
		|=> cnt_q == 9'h000)
		else $error("divider did not wrap at period");

	a_lag_value: assert property (@(posedge CLK) disable iff (!rst_n_q)
		setup_q[4:0] == 5'h10 |-> lag_cyc == period_cyc >> 1)
		else $error("half period lag wrong");

	a_on_start: assert property (@(posedge CLK) disable iff (!rst_n_q)
		$rose(pwm_q) && $past(CONV_ON, 2) && $past(locked_q, 2) &&
		!$past(sync_edge, 2) && $stable(setup_q)
		|-> $past(cnt_q) == lag_cyc)
		else $error("on-time not at lag");

	a_duty_cap: assert property (@(posedge CLK) disable iff (!rst_n_q)
		pos == 9'h000 |=> on_q <= $past(ceil_cyc))
		else $error("on-time above ceiling");

	a_sat_high: assert property (@(posedge CLK) disable iff (!rst_n_q)
		pos == 9'h000 && upper_saturation_enable && ERR_HIGH
		|=> on_q == $past(ceil_cyc))
		else $error("high saturation missed");

	a_sat_low: assert property (@(posedge CLK) disable iff (!rst_n_q)
		pos == 9'h000 && negative_saturation_enable && ERR_LOW &&
		!(upper_saturation_enable && ERR_HIGH) |=> on_q == 9'h000)
		else $error("low saturation missed");

	a_off_quiet: assert property (@(posedge CLK) disable iff (!rst_n_q)
		!CONV_ON |=> !PWM_OUT)
		else $error("pwm active while off");
endmodule : synced_pwm_phase_and_rate_setup

// ### verif/sync_master.sv
/* power manager model: master clock pulses on the shared sync line.
   assumes the block samples the sync line on rising clk. */
`timescale 1ns/10ps
module sync_master #(
	parameter int PERIOD = 1000
) (
	input  wire logic clk,
	output logic      sync_line
);
	int cnt = 0;
	initial sync_line = 1'b0;
	// one-cycle pulse per master period, launched off the sampling edge
	always @(negedge clk) begin
		cnt = (cnt == PERIOD - 1) ? 0 : cnt + 1;
		sync_line <= (cnt == 0);
	end
endmodule : sync_master

// ### verif/tb.sv
/* self-checking bench for the pwm phase and rate setup block.
   assumes the sync master pulses every 1000 clk cycles. */
`timescale 1ns/10ps
module tb;
	logic       clk, reset_n, conv_on, reg_wr, reg_sel;
	logic       err_high, err_low, sync_line, pwm;
	logic [7:0] wdata, rdata;
	logic [8:0] duty;
	int         err_total = 0;
	int         n_compared = 0;
	int         cycles = 0;
	int         d, g, w;
	synced_pwm_phase_and_rate_setup DUT (.CLK(clk), .RESET_N(reset_n),
		.SYNC_IN(sync_line), .CONV_ON(conv_on), .REG_WR(reg_wr),
		.REG_SEL(reg_sel), .REG_WDATA(wdata), .REG_RDATA(rdata),
		.DUTY_REQ(duty), .ERR_HIGH(err_high), .ERR_LOW(err_low),
		.PWM_OUT(pwm));
	sync_master #(.PERIOD(1000)) PM (.clk(clk), .sync_line(sync_line));
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// hang guard: the whole run needs well under 60000 cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			stop_test();
		end
	end
	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	task automatic check(string what, logic [9:0] exp, logic [9:0] got);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s: expected %0d seen %0d", what, exp, got);
		end
	endtask : check
	task automatic wr(logic sel, logic [7:0] v);
		@(negedge clk);
		reg_wr = 1'b1;
		reg_sel = sel;
		wdata = v;
		@(negedge clk);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(logic sel, output logic [7:0] v);
		@(negedge clk);
		reg_sel = sel;
		repeat (3) @(negedge clk);
		v = rdata;
	endtask : rd
	// second sync after a change, so the old on-time has flushed out;
	// pwm is read at negedge, away from the edge that launches it, and a
	// lagged pulse wrapping past the sync is skipped before timing the rise
	task automatic measure();
		int n;
		int m;
		repeat (2) begin
			@(posedge clk);
			for (n = 0; n < 1100 && sync_line !== 1'b1; n++) @(posedge clk);
		end
		@(negedge clk);
		for (n = 0; n < 1000 && pwm === 1'b1; n++) @(negedge clk);
		for (m = 0; m < 1000 && pwm !== 1'b1; m++) @(negedge clk);
		d = n + m;
		for (n = 0; n < 1000 && pwm === 1'b1; n++) @(negedge clk);
		w = n;
		for (m = 0; m < 1000 && pwm !== 1'b1; m++) @(negedge clk);
		g = w + m;
	endtask : measure
	task automatic t_reset();
		logic [7:0] v;
		rd(1'b0, v);
		check("setup reset", 10'h000, {2'b00, v});
		rd(1'b1, v);
		check("ceiling reset", 10'h0e8, {2'b00, v});
		$display("test reset done");
	endtask : t_reset
	task automatic t_rate();
		// code 3 is unused and must fall back to the lowest rate
		int per[4] = '{500, 333, 250, 500};
		for (int r = 0; r < 4; r++) begin
			conv_on = 1'b0;
			wr(1'b0, {3'(r), 5'h00});
			conv_on = 1'b1;
			measure();
			check("period", 10'(per[r]), 10'(g));
		end
		conv_on = 1'b0;
		$display("test rate done");
	endtask : t_rate
	task automatic t_lag();
		int base;
		int codes[3] = '{0, 1, 31};
		for (int i = 0; i < 3; i++) begin
			wr(1'b0, {3'h0, 5'(codes[i])});
			conv_on = 1'b1;
			measure();
			if (i == 0)
				base = d;
			check("lag", 10'(500 * codes[i] / 32), 10'(d - base));
			conv_on = 1'b0;
		end
		$display("test lag done");
	endtask : t_lag
	task automatic t_ceil();
		wr(1'b0, 8'h00);
		conv_on = 1'b1;
		duty = 9'h12c;
		measure();
		check("capped on-time", 10'(500 * 58 / 192), 10'(w));
		wr(1'b1, {6'h14, 2'b10});
		duty = 9'h00a;
		err_high = 1'b1;
		measure();
		check("high saturation", 10'(500 * 20 / 192), 10'(w));
		err_high = 1'b0;
		err_low = 1'b1;
		wr(1'b1, {6'h14, 2'b01});
		measure();
		check("low saturation", 10'h000, 10'(w));
		err_low = 1'b0;
		$display("test ceiling done");
	endtask : t_ceil
	task automatic t_lock();
		logic [7:0] v;
		wr(1'b0, 8'h40);
		rd(1'b0, v);
		check("setup while on", 10'h000, {2'b00, v});
		measure();
		check("period kept", 10'd500, 10'(g));
		conv_on = 1'b0;
		measure();
		check("off width", 10'h000, 10'(w));
		$display("test lock done");
	endtask : t_lock
	initial begin
		reset_n = 1'b0;
		conv_on = 1'b0;
		reg_wr = 1'b0;
		reg_sel = 1'b0;
		wdata = 8'h00;
		duty = 9'h064;
		err_high = 1'b0;
		err_low = 1'b0;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		repeat (4) @(negedge clk);
		t_reset();
		t_rate();
		t_lag();
		t_ceil();
		t_lock();
		stop_test();
	end
endmodule : tb
